// ---- hw/sdsp_pkg.sv ----
// Constants for the SPI data and status path.
// Assumes a byte-wide register bus with 32-bit read data.
package sdsp_pkg;
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   localparam int BIT_TX_EMPTY = 0;
   localparam int BIT_RX_FULL = 1;
   localparam int BIT_ACTIVE = 2;
   localparam int BIT_AUTO_READ = 5;
   localparam logic [2:0] STATUS_RESET = 3'h1;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam int CLK_FREQ_MHZ = 100;
   localparam int SCK_HALF_NS = 40;
   localparam int SCK_HALF_CYCLES = (SCK_HALF_NS * CLK_FREQ_MHZ + 999) / 1000;
   typedef enum logic [1:0] {SDSP_IDLE, SDSP_LOW, SDSP_HIGH} sdsp_state_t;
endpackage

// ---- hw/sdsp_core.sv ----
// SPI data buffers, status flags, interrupts and a mode-0 MSB-first shifter.
// Assumes a single-cycle register port master and an SPI slave on the pins.
//
// Behaviour
// - Status bit 1 rx full, read clears
// - Rx full rise latches receive interrupt event
// - Status bit 0 tx empty, reset one
// - Tx empty rise latches transmit interrupt event
// - Tx write while empty starts transfer
// - Idle shifter loads byte, empty set
// - Busy shifter: hold byte, load later
// - Byte end captures received byte, else marks it pending
// - Rx captured only while full clear or data being read
// - Pending rx loads when full clears
// - Auto-read clears both flags on read
`timescale 1ns/1ps
`default_nettype none
module sdsp_core (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Serial link
   output logic spi_sck,
   output logic spi_mosi,
   input wire logic spi_miso,
   // Interrupt
   output logic irq
);
   localparam int HW = sdsp_pkg::SCK_HALF_CYCLES;
   sdsp_pkg::sdsp_state_t state, next_state;
   logic [7:0] tx_hold, next_tx_hold, tx_shift, next_tx_shift;
   logic [7:0] rx_shift, next_rx_shift, rx_hold, next_rx_hold;
   logic tx_pending, next_tx_pending, rx_pending, next_rx_pending;
   logic tx_empty_flag, next_tx_empty_flag, rx_full_flag, next_rx_full_flag;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [7:0] div_cnt, next_div_cnt;
   logic [7:0] control, next_control;
   logic [1:0] irq_status, next_irq_status, irq_mask, next_irq_mask;
   logic [31:0] next_rdata;
   logic sck, next_sck;
   logic miso_s1, miso_s2;
   logic wr_data, rd_data, byte_done, load_shift;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction

   // Miso is asynchronous to ref_clk
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         miso_s1 <= 1'b0;
         miso_s2 <= 1'b0;
      end else begin
         miso_s1 <= spi_miso;
         miso_s2 <= miso_s1;
      end
   end

   assign wr_data = reg_wr && hit(reg_addr, sdsp_pkg::ADDR_DATA);
   assign rd_data = reg_rd && hit(reg_addr, sdsp_pkg::ADDR_DATA);

   always_comb begin
      next_state = state;
      next_tx_hold = tx_hold;
      next_tx_shift = tx_shift;
      next_rx_shift = rx_shift;
      next_rx_hold = rx_hold;
      next_tx_pending = tx_pending;
      next_rx_pending = rx_pending;
      next_tx_empty_flag = tx_empty_flag;
      next_rx_full_flag = rx_full_flag;
      next_bit_cnt = bit_cnt;
      next_div_cnt = div_cnt;
      next_sck = sck;
      next_control = control;
      next_irq_mask = irq_mask;
      next_irq_status = irq_status;
      next_rdata = 32'h0000_0000;
      byte_done = 1'b0;
      load_shift = 1'b0;
      if (reg_wr && hit(reg_addr, sdsp_pkg::ADDR_CONTROL)) begin
         next_control = reg_wdata[7:0];
      end
      if (reg_wr && hit(reg_addr, sdsp_pkg::ADDR_IRQ_MASK)) begin
         next_irq_mask = reg_wdata[1:0];
      end
      // Reads of the rx register clear full; auto-read clears empty too
      if (rd_data) begin
         next_rx_full_flag = 1'b0;
         if (control[sdsp_pkg::BIT_AUTO_READ]) begin
            next_tx_empty_flag = 1'b0;
         end
      end
      // Write parks the byte; the shifter picks it up when idle or at the end of its current byte
      if (wr_data) begin
         next_tx_hold = reg_wdata[7:0];
         next_tx_pending = 1'b1;
         next_tx_empty_flag = 1'b0;
      end
      case (state)
         sdsp_pkg::SDSP_IDLE: begin
            if (tx_pending) begin
               load_shift = 1'b1;
            end
         end
         sdsp_pkg::SDSP_LOW: begin
            if (div_cnt == 8'(HW - 1)) begin
               next_div_cnt = 8'h00;
               next_sck = 1'b1;
               next_rx_shift = {rx_shift[6:0], miso_s2};
               next_state = sdsp_pkg::SDSP_HIGH;
            end else begin
               next_div_cnt = div_cnt + 8'h01;
            end
         end
         sdsp_pkg::SDSP_HIGH: begin
            if (div_cnt == 8'(HW - 1)) begin
               next_div_cnt = 8'h00;
               next_sck = 1'b0;
               if (bit_cnt == 3'h7) begin
                  byte_done = 1'b1;
                  next_state = sdsp_pkg::SDSP_IDLE;
               end else begin
                  next_bit_cnt = bit_cnt + 3'h1;
                  next_tx_shift = {tx_shift[6:0], 1'b0};
                  next_state = sdsp_pkg::SDSP_LOW;
               end
            end else begin
               next_div_cnt = div_cnt + 8'h01;
            end
         end
         default: next_state = sdsp_pkg::SDSP_IDLE;
      endcase
      // Back-to-back bytes chain without an idle gap
      if (byte_done && tx_pending) begin
         load_shift = 1'b1;
      end
      if (load_shift) begin
         next_tx_shift = tx_hold;
         next_tx_pending = wr_data;
         next_tx_empty_flag = 1'b1;
         next_bit_cnt = 3'h0;
         next_div_cnt = 8'h00;
         next_state = sdsp_pkg::SDSP_LOW;
      end
      if (byte_done) begin
         next_rx_pending = 1'b1;
      end
      // Pending rx byte moves only while the holding register is free
      if ((byte_done || rx_pending) && !(rx_full_flag && !rd_data)) begin
         next_rx_hold = byte_done ? next_rx_shift : rx_shift;
         next_rx_full_flag = 1'b1;
         next_rx_pending = 1'b0;
      end
      // Sticky events: set wins over read-clear
      if (reg_rd && hit(reg_addr, sdsp_pkg::ADDR_IRQ_STATUS)) begin
         next_irq_status = 2'h0;
      end
      if (next_tx_empty_flag && !tx_empty_flag) begin
         next_irq_status[sdsp_pkg::BIT_TX_EMPTY] = 1'b1;
      end
      if (next_rx_full_flag && !rx_full_flag) begin
         next_irq_status[sdsp_pkg::BIT_RX_FULL] = 1'b1;
      end
      if (reg_rd) begin
         if (hit(reg_addr, sdsp_pkg::ADDR_DATA)) begin
            next_rdata = {24'h00_0000, rx_hold};
         end else if (hit(reg_addr, sdsp_pkg::ADDR_STATUS)) begin
            next_rdata = {29'h0, state != sdsp_pkg::SDSP_IDLE, rx_full_flag, tx_empty_flag};
         end else if (hit(reg_addr, sdsp_pkg::ADDR_CONTROL)) begin
            next_rdata = {24'h00_0000, control};
         end else if (hit(reg_addr, sdsp_pkg::ADDR_IRQ_STATUS)) begin
            next_rdata = {30'h0, irq_status};
         end else if (hit(reg_addr, sdsp_pkg::ADDR_IRQ_MASK)) begin
            next_rdata = {30'h0, irq_mask};
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= sdsp_pkg::SDSP_IDLE;
         tx_hold <= 8'h00;
         tx_shift <= 8'h00;
         rx_shift <= 8'h00;
         rx_hold <= 8'h00;
         tx_pending <= 1'b0;
         rx_pending <= 1'b0;
         tx_empty_flag <= sdsp_pkg::STATUS_RESET[sdsp_pkg::BIT_TX_EMPTY];
         rx_full_flag <= sdsp_pkg::STATUS_RESET[sdsp_pkg::BIT_RX_FULL];
         bit_cnt <= 3'h0;
         div_cnt <= 8'h00;
         sck <= 1'b0;
         control <= sdsp_pkg::CONTROL_RESET;
         irq_status <= 2'h0;
         irq_mask <= sdsp_pkg::MASK_RESET;
         reg_rdata <= 32'h0000_0000;
      end else begin
         state <= next_state;
         tx_hold <= next_tx_hold;
         tx_shift <= next_tx_shift;
         rx_shift <= next_rx_shift;
         rx_hold <= next_rx_hold;
         tx_pending <= next_tx_pending;
         rx_pending <= next_rx_pending;
         tx_empty_flag <= next_tx_empty_flag;
         rx_full_flag <= next_rx_full_flag;
         bit_cnt <= next_bit_cnt;
         div_cnt <= next_div_cnt;
         sck <= next_sck;
         control <= next_control;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         reg_rdata <= next_rdata;
      end
   end

   assign spi_sck = sck;
   assign spi_mosi = tx_shift[7];
   // Level interrupt from latched events only, not from flags still standing
   assign irq = |(irq_status & irq_mask);

   chk_rx_read_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_data && !rx_pending && !byte_done |=> !rx_full_flag)
      else $error("rx full not cleared by read");
   chk_tx_write_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_data && state != sdsp_pkg::SDSP_IDLE && !byte_done |=> !tx_empty_flag)
      else $error("tx empty not cleared by write");
   chk_idle_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_data && state == sdsp_pkg::SDSP_IDLE && !tx_pending |=> ##1 tx_empty_flag && state == sdsp_pkg::SDSP_LOW)
      else $error("idle write did not load shifter");
   chk_start_xfer: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_data && tx_empty_flag |-> ##[1:200] state != sdsp_pkg::SDSP_IDLE)
      else $error("write did not start transfer");
   chk_byte_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
      byte_done && !rx_full_flag |=> rx_full_flag && rx_hold == $past(next_rx_shift))
      else $error("byte not captured");
   chk_rx_hold_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_full_flag && !rd_data |=> $stable(rx_hold))
      else $error("rx hold overwritten while full");
   chk_rx_pending_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_pending && rd_data |=> rx_full_flag && !rx_pending)
      else $error("pending rx not loaded");
   chk_auto_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_data && control[sdsp_pkg::BIT_AUTO_READ] && !load_shift |=> !tx_empty_flag)
      else $error("auto read left tx empty set");
   chk_chain_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
      byte_done && tx_pending |=> tx_empty_flag && state == sdsp_pkg::SDSP_LOW && bit_cnt == 3'h0)
      else $error("pending tx not chained");
   chk_active_sck: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state == sdsp_pkg::SDSP_IDLE |-> !sck)
      else $error("clock toggles while idle");
   chk_irq_sources: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(rx_full_flag) |=> irq_status[sdsp_pkg::BIT_RX_FULL] || $past(reg_rd))
      else $error("rx full event lost");

   // Read data stands one cycle only, so a stale word never looks fresh
   chk_rdata_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside read cycle");
   chk_status_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_rd && reg_addr == sdsp_pkg::ADDR_STATUS |=> reg_rdata[1:0] == $past({rx_full_flag, tx_empty_flag}))
      else $error("status flags misreported");
   chk_active_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_rd && reg_addr == sdsp_pkg::ADDR_STATUS
      |=> reg_rdata[sdsp_pkg::BIT_ACTIVE] == $past(state != sdsp_pkg::SDSP_IDLE))
      else $error("active bit misreported");

   // Events are flag edges; a set beats a read-clear in the same cycle
   chk_tx_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(tx_empty_flag) |-> irq_status[sdsp_pkg::BIT_TX_EMPTY])
      else $error("tx empty event lost");
   chk_rx_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(rx_full_flag) |-> irq_status[sdsp_pkg::BIT_RX_FULL])
      else $error("rx full event not recorded");

   // Link timing: four cycles per clock phase, eight bits per byte
   chk_sck_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(sck) |-> sck[*4] ##1 !sck)
      else $error("serial clock high phase wrong");
   chk_mosi_steady: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sck |-> $stable(spi_mosi))
      else $error("mosi moved while clock high");
   chk_byte_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(state) == sdsp_pkg::SDSP_IDLE && state == sdsp_pkg::SDSP_LOW |-> ##63 byte_done)
      else $error("byte length wrong");
   chk_idle_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_data && state == sdsp_pkg::SDSP_IDLE && !tx_pending |=> !tx_empty_flag && tx_pending)
      else $error("idle write not parked");
endmodule
`default_nettype wire

// ---- dv/sdsp_slave_model.sv ----
// SPI slave model: mode 0, MSB first, one reply byte per frame.
// Assumes the master idles the clock low and uses no chip select.
`timescale 1ns/1ps
`default_nettype none
module sdsp_slave_model (
   // Serial link
   input wire logic spi_sck,
   input wire logic spi_mosi,
   output logic spi_miso,
   // Bench side
   input wire logic [7:0] reply,
   output logic [7:0] got
);
   logic [7:0] sh_out;
   logic [7:0] sh_in;
   int cnt;
   initial begin
      cnt = 0;
      sh_out = 8'h00;
      sh_in = 8'h00;
      got = 8'h00;
   end
   // Bit 7 must stand before the first rise, so it comes straight from reply
   assign spi_miso = (cnt == 0) ? reply[7] : sh_out[7];
   always @(posedge spi_sck) begin
      if (cnt == 0)
         sh_out = reply;
      sh_in = {sh_in[6:0], spi_mosi};
      cnt = cnt + 1;
      if (cnt == 8)
         got = sh_in;
   end
   // Fill with inverted bits so a stale line never looks like data
   always @(negedge spi_sck) begin
      if (cnt == 8)
         cnt = 0;
      else
         sh_out = {sh_out[6:0], ~sh_out[7]};
   end
endmodule
`default_nettype wire

// ---- dv/sdsp_core_tb_top.sv ----
// Bench for the SPI data and status path against a slave model.
// Assumes the register map of sdsp_pkg and a mode-0 slave.
`timescale 1ns/1ps
`default_nettype none
module sdsp_core_tb_top;
   logic ref_clk;
   logic rst_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic spi_sck;
   logic spi_mosi;
   logic spi_miso;
   logic irq;
   logic [7:0] reply;
   logic [7:0] got;
   logic [31:0] rd;
   int fails;
   int comparisons;
   sdsp_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .irq(irq));
   sdsp_slave_model slave (.spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .reply(reply), .got(got));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   // Poll before reading the receive byte
   task automatic wait_full();
      int n;
      n = 0;
      rd = 32'h0000_0000;
      while (rd[1] !== 1'b1 && n < 100) begin
         reg_read(sdsp_pkg::ADDR_STATUS);
         n++;
      end
      check("rx full", {31'h0, rd[1]}, 32'h0000_0001);
   endtask
   task automatic t_reset();
      check("irq idle", {31'h0, irq}, 32'h0000_0000);
      reg_read(sdsp_pkg::ADDR_STATUS);
      check("status reset", rd, 32'h0000_0001);
      reg_write(sdsp_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
      reg_read(sdsp_pkg::ADDR_STATUS);
      check("status ro", rd, 32'h0000_0001);
      reg_read(8'h20);
      check("unmapped", rd, 32'h0000_0000);
      reg_write(sdsp_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
      reg_read(sdsp_pkg::ADDR_IRQ_STATUS);
   endtask
   task automatic t_single();
      reply = 8'h3C;
      reg_write(sdsp_pkg::ADDR_DATA, 32'h0000_00A5);
      repeat (3) @(posedge ref_clk);
      reg_read(sdsp_pkg::ADDR_STATUS);
      check("busy", rd, 32'h0000_0005);
      wait_full();
      check("irq up", {31'h0, irq}, 32'h0000_0001);
      reg_read(sdsp_pkg::ADDR_IRQ_STATUS);
      check("irq events", rd, 32'h0000_0003);
      repeat (2) @(posedge ref_clk);
      check("irq down", {31'h0, irq}, 32'h0000_0000);
      check("mosi byte", {24'h0, got}, 32'h0000_00A5);
      reg_read(sdsp_pkg::ADDR_DATA);
      check("rx byte", rd, 32'h0000_003C);
      reg_read(sdsp_pkg::ADDR_STATUS);
      check("after read", rd, 32'h0000_0001);
   endtask
   // Second byte lands in the shift register while the first is unread
   task automatic t_b2b();
      reply = 8'h81;
      reg_write(sdsp_pkg::ADDR_DATA, 32'h0000_0011);
      repeat (3) @(posedge ref_clk);
      reg_write(sdsp_pkg::ADDR_DATA, 32'h0000_0022);
      repeat (3) @(posedge ref_clk);
      reg_read(sdsp_pkg::ADDR_STATUS);
      check("pending", rd, 32'h0000_0004);
      reply = 8'h7E;
      wait_full();
      repeat (90) @(posedge ref_clk);
      reg_read(sdsp_pkg::ADDR_STATUS);
      check("both done", rd, 32'h0000_0003);
      check("mosi 2nd", {24'h0, got}, 32'h0000_0022);
      reg_read(sdsp_pkg::ADDR_DATA);
      check("rx first", rd, 32'h0000_0081);
      reg_read(sdsp_pkg::ADDR_STATUS);
      check("reload", rd, 32'h0000_0003);
      reg_read(sdsp_pkg::ADDR_DATA);
      check("rx second", rd, 32'h0000_007E);
      reg_read(sdsp_pkg::ADDR_STATUS);
      check("drained", rd, 32'h0000_0001);
   endtask
   // Last: auto-read leaves tx empty low, so no write may follow
   task automatic t_auto();
      reply = 8'h96;
      reg_write(sdsp_pkg::ADDR_CONTROL, 32'h0000_0020);
      reg_read(sdsp_pkg::ADDR_CONTROL);
      check("control", rd, 32'h0000_0020);
      reg_write(sdsp_pkg::ADDR_DATA, 32'h0000_005A);
      wait_full();
      reg_read(sdsp_pkg::ADDR_DATA);
      check("rx auto", rd, 32'h0000_0096);
      reg_read(sdsp_pkg::ADDR_STATUS);
      check("auto clear", rd, 32'h0000_0000);
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      summarize();
   end
   initial begin
      fails = 0;
      comparisons = 0;
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reply = 8'h00;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_single();
      t_b2b();
      t_auto();
      summarize();
   end
endmodule
`default_nettype wire
